// >>> hdl/nfh_pkg.sv
// Shared constants and types for the flash host port controller
package nfh_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_OP = 8'h00;
  localparam logic [7:0] OFS_COL = 8'h04;
  localparam logic [7:0] OFS_ROW = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // OP register fields
  localparam int OP_BYTE_LSB = 0;
  localparam int OP_KIND_LSB = 8;
  // CFG register fields and reset values
  localparam int CFG_CE_BIT = 0;
  localparam int CFG_WP_BIT = 1;
  localparam logic CFG_CE_RST = 1'b0;
  localparam logic CFG_WP_RST = 1'b0;
  // STATUS register fields
  localparam int ST_ENGINE_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_OWED_BIT = 3;
  localparam int ST_DATA_LSB = 8;
  // Operation kinds written to OP
  localparam logic [2:0] KIND_CMD = 3'h0;
  localparam logic [2:0] KIND_ADDR = 3'h1;
  localparam logic [2:0] KIND_DIN = 3'h2;
  localparam logic [2:0] KIND_DOUT = 3'h3;
  localparam logic [2:0] KIND_ADDR5 = 3'h4;
  localparam logic [2:0] KIND_ADDR2 = 3'h5;
  // Address layout
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  // Command codes the controller must track
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_MULTI_LEAD = 8'h81;
  localparam logic [7:0] CMD_CACHE_CONFIRM = 8'h15;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  // Pin timing in ns and derived cycles at clk_sys
  localparam int CLK_MHZ = 200;
  localparam int T_PULSE_NS = 12;
  localparam int T_HIGH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_WB_NS = 100;
  localparam int SYNC_LAG = 3;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_CYC = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_LOW_CYC = (T_REA_NS * CLK_MHZ + 999) / 1000 + SYNC_LAG;
  localparam int GAP_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_RDY, ST_LOW, ST_HIGH, ST_GAP} nfh_state_t;
endpackage

// >>> hdl/nfh_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module nfh_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  if (WIDTH < 1) begin : g_bad_width
    $error("nfh_sync WIDTH must be at least 1");
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule // nfh_sync
`default_nettype wire

// >>> hdl/nfh_timer.sv
// Loadable down-counter for strobe phase timing
`timescale 1ns/1ps
`default_nettype none
module nfh_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_ff;
  // The longest phase count must fit
  if (WIDTH < 5) begin : g_bad_width
    $error("nfh_timer WIDTH too small for phase counts");
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  assign done = (cnt_ff == '0);
endmodule // nfh_timer
`default_nettype wire

// >>> hdl/nfh_ctrl.sv
// Host controller driving a NAND flash port, with Wishbone registers
// Overview of operation
// [R01] Command byte is latched on write strobe rise with command latch high.
// [R02] Address byte is latched on write strobe rise with address latch high.
// [R03] Device enters standby when chip select rises while ready.
// [R04] Device ignores chip select rise while busy.
// [R05] Device presents next byte and bumps column on output strobe fall.
// [R06] Program lock low inhibits device programming and erasing.
// [R07] Device pulls busy line low during program, erase and read.
// [R08] Page is 2048 main plus 128 spare bytes, programmed whole.
// [R09] Array is 2048 blocks of 64 pages, erased whole.
// [R10] Address is five cycles: 12-bit column then 17-bit row.
// [R11] Upper eleven row bits are block, lower six are page.
// [R12] Cycle type chosen by latch levels; data-in needs program lock high.
// [R13] While device busy, write and output strobes stay high; the controller pulses them for status and reset commands and status reads.
// [R14] Device takes only status and reset commands while busy.
// [R15] Device decodes read, column change and cached read commands.
// [R16] Device decodes program, cache program and input column change.
// [R17] Device decodes page copy read and page copy programs.
// [R18] Device decodes erase and identification read commands.
// [R19] Cached multi-page program should end with 81h then 10h.
// [R20] After 81h then 15h, poll status then issue reset before next operation.
// [R21] Device drives bus only while output strobe is low.
// [R22] Device preloads read setup at power-on.
// [R23] Wait for ready before commands not accepted while busy.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic chip_sel_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic prog_lock_n,
  input wire logic busy_flag_n,
  input wire logic [7:0] shared_bus_i,
  output logic [7:0] shared_bus_o,
  output logic shared_bus_oe
);
  logic wb_ack_ff;
  logic [31:0] op_ff, col_ff, row_ff, cfg_ff;
  logic op_go_ff, refused_ff, owed_ff, status_mode_ff;
  logic [7:0] prev_cmd_ff, rd_data_ff;
  logic [2:0] idx_ff;
  nfh_pkg::nfh_state_t state_ff, nxt_state;
  logic ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, oe_ff, lock_n_ff;
  logic [7:0] bus_o_ff;
  logic [8:0] pins_s;
  logic tdone;
  logic [7:0] tval;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic busy_ok(input logic [7:0] b);
    return (b == nfh_pkg::CMD_STATUS) || (b == nfh_pkg::CMD_STATUS_MULTI) || (b == nfh_pkg::CMD_RESET);
  endfunction

  // Wishbone decode; ack one cycle after the strobe
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  wire wb_wr = wb_hit & wb_we_i;
  wire engine_busy = (state_ff != nfh_pkg::ST_IDLE) | op_go_ff;
  // OP writes while an operation runs are dropped
  wire wr_op = wb_wr & (wb_adr_i == nfh_pkg::OFS_OP) & ~engine_busy;
  wire wr_col = wb_wr & (wb_adr_i == nfh_pkg::OFS_COL);
  wire wr_row = wb_wr & (wb_adr_i == nfh_pkg::OFS_ROW);
  wire wr_cfg = wb_wr & (wb_adr_i == nfh_pkg::OFS_CFG);

  wire [7:0] op_byte = op_ff[nfh_pkg::OP_BYTE_LSB +: 8];
  wire [2:0] op_kind = op_ff[nfh_pkg::OP_KIND_LSB +: 3];
  wire [nfh_pkg::COL_W-1:0] col = col_ff[nfh_pkg::COL_W-1:0];
  wire [nfh_pkg::ROW_W-1:0] row = row_ff[nfh_pkg::ROW_W-1:0];
  wire cfg_ce = cfg_ff[nfh_pkg::CFG_CE_BIT];
  wire cfg_wp = cfg_ff[nfh_pkg::CFG_WP_BIT];
  wire ready_s = pins_s[8];
  wire [7:0] bus_s = pins_s[7:0];

  wire k_cmd = op_kind == nfh_pkg::KIND_CMD;
  wire k_dout = op_kind == nfh_pkg::KIND_DOUT;
  wire k_din = op_kind == nfh_pkg::KIND_DIN;
  wire k_addr = (op_kind == nfh_pkg::KIND_ADDR) | (op_kind == nfh_pkg::KIND_ADDR5) | (op_kind == nfh_pkg::KIND_ADDR2);
  wire [2:0] op_len = (op_kind == nfh_pkg::KIND_ADDR5) ? 3'h5 : (op_kind == nfh_pkg::KIND_ADDR2) ? 3'h2 : 3'h1;
  wire bypass = (k_cmd & busy_ok(op_byte)) | (k_dout & status_mode_ff);
  // [R12] Data-in refused with program lock low
  wire refuse_lock = k_din & ~cfg_wp;
  // [R20] Reset owed blocks other operations
  wire refuse_owed = owed_ff & ~bypass;
  wire refuse = refuse_lock | refuse_owed | (op_kind > nfh_pkg::KIND_ADDR2);

  // [R10] Column then row over five cycles
  wire [7:0] addr_byte = (idx_ff == 3'h0) ? col[7:0] :
                         (idx_ff == 3'h1) ? {4'h0, col[11:8]} :
                         (idx_ff == 3'h2) ? row[7:0] :
                         (idx_ff == 3'h3) ? row[15:8] : {7'h00, row[16]};
  wire [7:0] out_byte = (op_kind == nfh_pkg::KIND_ADDR) ? op_byte : k_addr ? addr_byte : op_byte;
  wire last_beat = (idx_ff == op_len - 3'h1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      nfh_pkg::ST_IDLE: begin
        if (op_go_ff && !refuse) begin
          nxt_state = nfh_pkg::ST_WAIT_RDY;
        end
      end
      // [R23] Hold until ready unless allowed while busy
      nfh_pkg::ST_WAIT_RDY: begin
        if (ready_s || bypass) begin
          nxt_state = nfh_pkg::ST_LOW;
        end
      end
      nfh_pkg::ST_LOW: begin
        if (tdone) begin
          nxt_state = nfh_pkg::ST_HIGH;
        end
      end
      nfh_pkg::ST_HIGH: begin
        if (tdone) begin
          nxt_state = !last_beat ? nfh_pkg::ST_LOW : k_cmd ? nfh_pkg::ST_GAP : nfh_pkg::ST_IDLE;
        end
      end
      nfh_pkg::ST_GAP: begin
        if (tdone) begin
          nxt_state = nfh_pkg::ST_IDLE;
        end
      end
      default: nxt_state = nfh_pkg::ST_IDLE;
    endcase
  end

  // Gap after a command covers the busy onset delay
  assign tval = (nxt_state == nfh_pkg::ST_LOW) ? 8'(k_dout ? nfh_pkg::RD_LOW_CYC - 1 : nfh_pkg::PULSE_CYC - 1) :
                (nxt_state == nfh_pkg::ST_HIGH) ? 8'(nfh_pkg::HIGH_CYC - 1) :
                (nxt_state == nfh_pkg::ST_GAP) ? 8'(nfh_pkg::GAP_CYC - 1) : 8'h00;
  wire tload = nxt_state != state_ff;
  wire cmd_done = (state_ff == nfh_pkg::ST_HIGH) & tdone & k_cmd;

  nfh_timer #(.WIDTH(8)) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(tload),
    .load_val(tval),
    .done(tdone)
  );

  nfh_sync #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_in({busy_flag_n, shared_bus_i}),
    .sync_out(pins_s)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_ff <= 1'b0;
      op_ff <= 32'h0000_0000;
      col_ff <= 32'h0000_0000;
      row_ff <= 32'h0000_0000;
      cfg_ff <= {30'h0, nfh_pkg::CFG_WP_RST, nfh_pkg::CFG_CE_RST};
      op_go_ff <= 1'b0;
    end else begin
      wb_ack_ff <= wb_hit;
      op_go_ff <= wr_op;
      if (wr_op) op_ff <= merge(op_ff, wb_dat_i, wb_sel_i);
      if (wr_col) col_ff <= merge(col_ff, wb_dat_i, wb_sel_i);
      if (wr_row) row_ff <= merge(row_ff, wb_dat_i, wb_sel_i);
      if (wr_cfg) cfg_ff <= merge(cfg_ff, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= nfh_pkg::ST_IDLE;
      idx_ff <= 3'h0;
      refused_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == nfh_pkg::ST_IDLE) idx_ff <= 3'h0;
      else if (state_ff == nfh_pkg::ST_HIGH && nxt_state == nfh_pkg::ST_LOW) idx_ff <= idx_ff + 3'h1;
      if (op_go_ff) refused_ff <= refuse;
      if (state_ff == nfh_pkg::ST_LOW && tdone && k_dout) rd_data_ff <= bus_s;
    end
  end

  // [R19] Track the multi-page confirm pair
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_cmd_ff <= 8'h00;
      owed_ff <= 1'b0;
      status_mode_ff <= 1'b0;
    end else if (cmd_done) begin
      prev_cmd_ff <= op_byte;
      status_mode_ff <= (op_byte == nfh_pkg::CMD_STATUS) | (op_byte == nfh_pkg::CMD_STATUS_MULTI);
      // [R20] Reset owed after 81h-15h
      if (op_byte == nfh_pkg::CMD_RESET) owed_ff <= 1'b0;
      else if (op_byte == nfh_pkg::CMD_CACHE_CONFIRM && prev_cmd_ff == nfh_pkg::CMD_MULTI_LEAD) owed_ff <= 1'b1;
    end
  end

  // Pins from flops; latches are set at least one cycle before the strobe falls
  wire act = (state_ff == nfh_pkg::ST_WAIT_RDY) | (state_ff == nfh_pkg::ST_LOW) | (state_ff == nfh_pkg::ST_HIGH);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ce_n_ff <= 1'b1;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      lock_n_ff <= 1'b0;
      bus_o_ff <= 8'h00;
    end else begin
      ce_n_ff <= ~(cfg_ce | (state_ff != nfh_pkg::ST_IDLE));
      // [R01] Command latch level
      cle_ff <= act & k_cmd;
      // [R02] Address latch level
      ale_ff <= act & k_addr;
      // [R13] Strobes only pulse in the low phase
      we_n_ff <= ~((state_ff == nfh_pkg::ST_LOW) & ~k_dout);
      re_n_ff <= ~((state_ff == nfh_pkg::ST_LOW) & k_dout);
      oe_ff <= act & ~k_dout;
      lock_n_ff <= cfg_wp;
      bus_o_ff <= out_byte;
    end
  end

  assign chip_sel_n = ce_n_ff;
  assign cmd_latch = cle_ff;
  assign addr_latch = ale_ff;
  assign write_strobe_n = we_n_ff;
  assign output_strobe_n = re_n_ff;
  assign prog_lock_n = lock_n_ff;
  assign shared_bus_o = bus_o_ff;
  assign shared_bus_oe = oe_ff;
  assign wb_ack_o = wb_ack_ff;

  logic [31:0] rd_mux;
  assign rd_mux = (wb_adr_i == nfh_pkg::OFS_OP) ? op_ff :
                  (wb_adr_i == nfh_pkg::OFS_COL) ? col_ff :
                  (wb_adr_i == nfh_pkg::OFS_ROW) ? row_ff :
                  (wb_adr_i == nfh_pkg::OFS_CFG) ? cfg_ff :
                  (wb_adr_i == nfh_pkg::OFS_STATUS) ? {16'h0000, rd_data_ff, 4'h0, owed_ff, refused_ff, ready_s,
                  engine_busy} : 32'h0000_0000;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) wb_dat_o <= 32'h0000_0000;
    else if (wb_hit) wb_dat_o <= rd_mux;
  end

  // Helper: write strobe rises counted per operation
  logic [2:0] we_rises_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) we_rises_ff <= 3'h0;
    else if (op_go_ff) we_rises_ff <= 3'h0;
    else if (!we_n_ff && state_ff != nfh_pkg::ST_LOW) we_rises_ff <= we_rises_ff + 3'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_CMD_LEVELS: assert property (cmd_latch && !write_strobe_n |-> !addr_latch && output_strobe_n && !chip_sel_n) // [R01]
    else $error("command cycle with wrong levels");
  AST_ADDR_LEVELS: assert property (addr_latch && !write_strobe_n |-> !cmd_latch && output_strobe_n) // [R02]
    else $error("address cycle with wrong levels");
  AST_ADDR_FIVE: assert property ($fell(addr_latch) && op_kind == nfh_pkg::KIND_ADDR5 |-> we_rises_ff == 3'h5) // [R10]
    else $error("full address not five cycles");
  AST_DIN_LOCK: assert property (!cmd_latch && !addr_latch && !write_strobe_n |-> prog_lock_n) // [R12]
    else $error("data input with program lock low");
  AST_BUSY_QUIET: assert property (state_ff == nfh_pkg::ST_WAIT_RDY && !ready_s && !bypass |=> ##1 write_strobe_n && output_strobe_n) // [R13]
    else $error("strobe pulsed while waiting on busy");
  AST_OWED_CMD: assert property (owed_ff && cmd_latch && $fell(write_strobe_n) |-> busy_ok(shared_bus_o)) // [R20]
    else $error("command other than status or reset while reset owed");
  AST_MULTI_END: assert property (cmd_done && op_byte == nfh_pkg::CMD_PROG_CONFIRM && !owed_ff |=> !owed_ff) // [R19]
    else $error("final confirm left reset owed");
  AST_WAIT_READY: assert property (state_ff == nfh_pkg::ST_WAIT_RDY && nxt_state == nfh_pkg::ST_LOW |-> ready_s || bypass) // [R23]
    else $error("operation started while device busy");
  AST_GAP_LEN: assert property ($rose(state_ff == nfh_pkg::ST_GAP) |-> (state_ff == nfh_pkg::ST_GAP) [*8] ##1 (state_ff == nfh_pkg::ST_GAP)) // [R23]
    else $error("post-command gap too short");

  COV_ADDR5: cover property ($fell(addr_latch) && op_kind == nfh_pkg::KIND_ADDR5);
  COV_READ: cover property ($rose(output_strobe_n) && k_dout);
  COV_OWED: cover property ($rose(owed_ff));
  COV_BUSY_WAIT: cover property (state_ff == nfh_pkg::ST_WAIT_RDY && !ready_s [*3]);
  COV_COL2: cover property ($fell(addr_latch) && op_kind == nfh_pkg::KIND_ADDR2);
endmodule // nfh_ctrl
`default_nettype wire

// >>> dv/nfh_flash_model.sv
// Behavioural flash device model for the host port bench
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
  parameter int BUSY_NS = 1500,
  parameter int ACC_NS = 8,
  // Arbitrary identification value
  parameter logic [7:0] ID_VAL = 8'h3C
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic pull_low
);
  logic [7:0] cmd = 8'h00;
  logic [11:0] col = 12'h000;
  logic [16:0] row = 17'h00000;
  logic [7:0] dat = 8'h00;
  logic [1:0] mode = 2'h0;
  logic rdy = 1'b1;
  logic oe = 1'b0;
  logic standby = 1'b0;
  int acnt = 0;
  logic [10:0] blk;
  logic [5:0] pg;
  assign blk = row[16:6];
  assign pg = row[5:0];
  assign pull_low = !rdy;
  // Released bus shows inverse, not last value
  assign bus_out = oe ? dat : ~dat;
  always @(negedge rdy) begin
    #BUSY_NS;
    rdy = 1'b1;
  end
  always @(posedge we_n) if (!ce_n && cle && !ale && (rdy || bus_in inside {8'h70, 8'h71, 8'hFF})) begin
    mode = 2'h0;
    acnt = (bus_in == 8'h60) ? 2 : 0;
    case (bus_in)
      // Read confirms need the read setup code latched
      8'h30, 8'h3A: if (cmd == 8'h00) rdy = 1'b0;
      8'h31, 8'h3F: rdy = 1'b0;
      8'h10, 8'h15, 8'h11, 8'hD0: if (wp_n) rdy = 1'b0;
      8'h70, 8'h71: mode = 2'h1;
      8'h90: mode = 2'h2;
      default: cmd = bus_in;
    endcase
  end
  always @(posedge we_n) if (!ce_n && ale && !cle && rdy) begin
    case (acnt)
      0: col[7:0] = bus_in;
      1: col[11:8] = bus_in[3:0];
      2: row[7:0] = bus_in;
      3: row[15:8] = bus_in;
      default: row[16] = bus_in[0];
    endcase
    acnt++;
  end
  always @(ce_n) standby = ce_n && rdy;
  always @(negedge re_n) if (!ce_n && we_n) begin
    #ACC_NS;
    dat = (mode == 2'h1) ? {1'b0, rdy, 6'h00} : (mode == 2'h2) ? ID_VAL : col[7:0] ^ 8'h5A;
    oe = 1'b1;
    if (mode == 2'h0) col = (col == 12'h87F) ? 12'h000 : col + 12'h001;
  end
  always @(posedge re_n) oe = 1'b0;
endmodule // nfh_flash_model
`default_nettype wire

// >>> dv/nfh_ctrl_tb_top.sv
// Self-checking bench for the flash host port controller
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF;
  logic [31:0] dr, q;
  logic ack, ce_n, cle, ale, wen, ren, wpn, oe, pull, busy_flag_n;
  logic [7:0] bo, bi, dbus, b;
  logic [11:0] col;
  logic [16:0] row;
  logic [7:0] exp_q[$];
  int fails = 0;
  int num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  assign busy_flag_n = pull ? 1'b0 : 1'b1;
  assign bi = oe ? bo : dbus;
  nfh_ctrl nfh_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .chip_sel_n(ce_n),
    .cmd_latch(cle), .addr_latch(ale), .write_strobe_n(wen), .output_strobe_n(ren), .prog_lock_n(wpn),
    .busy_flag_n(busy_flag_n), .shared_bus_i(bi), .shared_bus_o(bo), .shared_bus_oe(oe));
  nfh_flash_model nfh_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(wen), .re_n(ren),
    .wp_n(wpn), .bus_in(bi), .bus_out(dbus), .pull_low(pull));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= lanes;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fails++;
      stop_test;
    end
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // Poll STATUS with a bound of 3000 reads, well above the flash busy time
  task st_wait(input int bitn, input logic val);
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys);
    do begin
      rd(nfh_pkg::OFS_STATUS);
      n++;
    end while (q[bitn] !== val && n < 3000);
    if (q[bitn] !== val) begin
      fails++;
      stop_test;
    end
  endtask
  task op(input logic [2:0] k, input logic [7:0] v, input bit note);
    if (note) exp_q.push_back(v);
    wb(1'b1, nfh_pkg::OFS_OP, {21'h0, k, v});
    st_wait(nfh_pkg::ST_ENGINE_BIT, 1'b0);
  endtask
  task addr5;
    exp_q.push_back(col[7:0]);
    exp_q.push_back({4'h0, col[11:8]});
    exp_q.push_back(row[7:0]);
    exp_q.push_back(row[15:8]);
    exp_q.push_back({7'h00, row[16]});
    op(nfh_pkg::KIND_ADDR5, 8'h00, 1'b0);
  endtask
  task erase;
    op(nfh_pkg::KIND_CMD, 8'h60, 1'b1);
    op(nfh_pkg::KIND_ADDR, row[7:0], 1'b1);
    op(nfh_pkg::KIND_ADDR, row[15:8], 1'b1);
    op(nfh_pkg::KIND_ADDR, {7'h00, row[16]}, 1'b1);
    op(nfh_pkg::KIND_CMD, 8'hD0, 1'b1);
  endtask
  task stat_byte(input logic [7:0] e);
    op(nfh_pkg::KIND_CMD, 8'h70, 1'b1);
    op(nfh_pkg::KIND_DOUT, 8'h00, 1'b0);
    rd(nfh_pkg::OFS_STATUS);
    check("status_byte", {24'h0, q[15:8]}, {24'h0, e});
  endtask
  // Every byte the device latches is compared with the oldest note
  always @(posedge wen) if (rstn === 1'b1 && ce_n === 1'b0) begin
    check("latch_pair", {31'h0, cle & ale}, 32'h0);
    if (exp_q.size() == 0) check("byte_extra", 32'h1, 32'h0);
    else check("strobe_byte", {24'h0, bo}, {24'h0, exp_q.pop_front()});
  end
  initial begin
    b = 8'($urandom(92071));
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check("ce_rst", {31'h0, ce_n}, 32'h1);
    check("lock_rst", {31'h0, wpn}, 32'h0);
    rd(nfh_pkg::OFS_CFG);
    check("cfg_rst", q, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    check("unmapped", q, 32'h0);
    // Only the enabled byte lane may change
    lanes = 4'h1;
    wb(1'b1, nfh_pkg::OFS_COL, 32'hFFFF_FFFF);
    lanes = 4'hF;
    rd(nfh_pkg::OFS_COL);
    check("sel_lane", q, 32'h0000_00FF);
    $display("test reset done");
    col = 12'($urandom % 2000);
    row = 17'($urandom);
    wb(1'b1, nfh_pkg::OFS_COL, {20'h0, col});
    wb(1'b1, nfh_pkg::OFS_ROW, {15'h0, row});
    // First read relies on the setup code held since power-on
    addr5;
    op(nfh_pkg::KIND_CMD, 8'h30, 1'b1);
    check("read_busy", {31'h0, busy_flag_n}, 32'h0);
    check("dev_row", {15'h0, nfh_flash_model_i.row}, {15'h0, row});
    check("dev_col", {20'h0, nfh_flash_model_i.col}, {20'h0, col});
    st_wait(nfh_pkg::ST_READY_BIT, 1'b1);
    for (int i = 0; i < 3; i++) begin
      op(nfh_pkg::KIND_DOUT, 8'h00, 1'b0);
      rd(nfh_pkg::OFS_STATUS);
      check("read_byte", {24'h0, q[15:8]}, {24'h0, 8'(col + 12'(i)) ^ 8'h5A});
    end
    check("standby", {31'h0, nfh_flash_model_i.standby}, 32'h1);
    $display("test read done");
    wb(1'b1, nfh_pkg::OFS_CFG, 32'h0);
    erase;
    check("locked_erase", {31'h0, busy_flag_n}, 32'h1);
    wb(1'b1, nfh_pkg::OFS_CFG, 32'h2);
    erase;
    check("busy_pin", {31'h0, busy_flag_n}, 32'h0);
    check("no_standby", {31'h0, nfh_flash_model_i.standby}, 32'h0);
    stat_byte(8'h00);
    st_wait(nfh_pkg::ST_READY_BIT, 1'b1);
    stat_byte(8'h40);
    $display("test erase done");
    wb(1'b1, nfh_pkg::OFS_CFG, 32'h0);
    op(nfh_pkg::KIND_DIN, b, 1'b0);
    rd(nfh_pkg::OFS_STATUS);
    check("din_refused", {31'h0, q[nfh_pkg::ST_REFUSED_BIT]}, 32'h1);
    wb(1'b1, nfh_pkg::OFS_CFG, 32'h2);
    op(nfh_pkg::KIND_CMD, 8'h80, 1'b1);
    addr5;
    op(nfh_pkg::KIND_DIN, b, 1'b1);
    col = 12'($urandom % 2000);
    wb(1'b1, nfh_pkg::OFS_COL, {20'h0, col});
    op(nfh_pkg::KIND_CMD, 8'h85, 1'b1);
    exp_q.push_back(col[7:0]);
    exp_q.push_back({4'h0, col[11:8]});
    op(nfh_pkg::KIND_ADDR2, 8'h00, 1'b0);
    check("dev_col2", {20'h0, nfh_flash_model_i.col}, {20'h0, col});
    op(nfh_pkg::KIND_DIN, b, 1'b1);
    op(nfh_pkg::KIND_CMD, 8'h10, 1'b1);
    check("prog_busy", {31'h0, busy_flag_n}, 32'h0);
    st_wait(nfh_pkg::ST_READY_BIT, 1'b1);
    $display("test program done");
    op(3'h6, b, 1'b0);
    rd(nfh_pkg::OFS_STATUS);
    check("kind_refused", {31'h0, q[nfh_pkg::ST_REFUSED_BIT]}, 32'h1);
    op(nfh_pkg::KIND_CMD, 8'h81, 1'b1);
    addr5;
    op(nfh_pkg::KIND_CMD, 8'h15, 1'b1);
    rd(nfh_pkg::OFS_STATUS);
    check("owed_set", {31'h0, q[nfh_pkg::ST_OWED_BIT]}, 32'h1);
    op(nfh_pkg::KIND_CMD, 8'h00, 1'b0);
    rd(nfh_pkg::OFS_STATUS);
    check("owed_refuse", {31'h0, q[nfh_pkg::ST_REFUSED_BIT]}, 32'h1);
    stat_byte(8'h00);
    st_wait(nfh_pkg::ST_READY_BIT, 1'b1);
    op(nfh_pkg::KIND_CMD, 8'hFF, 1'b1);
    rd(nfh_pkg::OFS_STATUS);
    check("owed_clear", {31'h0, q[nfh_pkg::ST_OWED_BIT]}, 32'h0);
    check("notes_left", 32'(exp_q.size()), 32'h0);
    $display("test multi program done");
    stop_test;
  end
endmodule // nfh_ctrl_tb_top
`default_nettype wire
